// ===== rtl/mbe_pkg.sv
// Function
// - address 0021 sets shift-right flag, enables shift write
// - shift right: bit 16 to 16, 14
// - address 0022 sets rotate-left flag, rotate write
// - rotate left: bit 16 to 1, up
// - address 0023 sets extract flag, extract write
// - extract: bits 8-14 into 1-7
// - mul/div load only in mul/div at transfer time
// - mul/div load: accum 16, low 14-1 up
// - position 1 set by multiply bit-one pulse
// - buffer clear from write or load, clear time
// - buffer cleared on any sense strobe
// - buffer read only with read timing pulse
// - 16-bit end-around-carry adder sums X and Y
// - Y from write lines, never X
// - X written only by accumulator copy
// - accumulator copy in extracode or add only
// - adder clear from Y writes, clears both
// - Y write: low 1-12 and high 13-16
// - low-only Y write leaves high zeros
// - shifted Y write in mul/div/counter shift
// - shifted Y: bit 16 to 16, 1; shifted
// - shifted Y position 1 inhibited three cases
// - editing flags set at timing pulse 2
// - address 0020 rotates word toward low end
// - other addresses write straight; edit inhibits low
package mbe_pkg;

    localparam int W = 16;

    // editing addresses (octal)
    localparam logic [11:0] ADDR_ROT_R   = 12'h010;
    localparam logic [11:0] ADDR_SHIFT_R = 12'h011;
    localparam logic [11:0] ADDR_ROT_L   = 12'h012;
    localparam logic [11:0] ADDR_EXTRACT = 12'h013;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BUFFER = 8'h08;
    localparam logic [7:0] OFS_ADDEND = 8'h0c;
    localparam logic [7:0] OFS_AUGEND = 8'h10;
    localparam logic [7:0] OFS_SUM    = 8'h14;

    // control register fields
    localparam int CTRL_CLR_EDIT = 0;
    localparam int CTRL_FORCE_CLR = 1;

    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [4:0] {
        MBE_IDLE     = 5'b00001,
        MBE_ROT_R    = 5'b00010,
        MBE_SHIFT_R  = 5'b00100,
        MBE_ROT_L    = 5'b01000,
        MBE_EXTRACT  = 5'b10000
    } mbe_edit_t;

endpackage

// ===== rtl/mbe_adder.sv
`timescale 1ns/1ps
module mbe_adder (
    input  wire logic [15:0] addend,
    input  wire logic [15:0] augend,
    input  wire logic        carry_in,
    input  wire logic        no_wraparound_carry,
    output logic      [15:0] sum,
    output logic             carry_out
);
    logic [16:0] first;
    logic [16:0] second;
    logic        wrap;

    // ones' complement add: carry out of bit 16 re-enters bit 1
    always_comb begin
        first     = {1'b0, addend} + {1'b0, augend}
                  + {16'h0000, carry_in};
        wrap      = first[16] & ~no_wraparound_carry;
        second    = {1'b0, first[15:0]} + {16'h0000, wrap};
        sum       = second[15:0];
        carry_out = first[16];
    end
endmodule

// ===== rtl/mbe_core.sv
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module mbe_core (
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer pulses
    input  wire logic        timing_pulse_2,
    input  wire logic        write_timing_pulse,
    input  wire logic        transfer_timing_pulse,
    input  wire logic        clear_timing_pulse,
    input  wire logic        read_timing_pulse,
    input  wire logic        memory_cycle_end,
    // address decode
    input  wire logic [11:0] mem_addr,
    // sequence generator pulses and instruction states
    input  wire logic        buffer_write_pulse_local,
    input  wire logic        muldiv_buffer_load_pulse,
    input  wire logic        multiply_bit_one_pulse,
    input  wire logic        buffer_read_pulse,
    input  wire logic        multiply_active,
    input  wire logic        divide_active,
    input  wire logic        extracode_active,
    input  wire logic        add_active,
    input  wire logic        accum_to_addend_pulse,
    input  wire logic        augend_write_pulse,
    input  wire logic        augend_low_only_pulse,
    input  wire logic        augend_shift_pulse,
    input  wire logic        carry_in_pulse,
    input  wire logic        no_wraparound_carry,
    input  wire logic        counter_shift_in_zero,
    input  wire logic        counter_shift_in_one,
    input  wire logic        erasable_sense_strobe,
    input  wire logic        fixed_sense_strobe,
    // data
    input  wire logic [15:0] write_lines,
    input  wire logic [15:0] accumulator,
    input  wire logic [15:0] low_reg,
    // outputs
    output logic      [15:0] buffer_value,
    output logic      [15:0] buffer_read_data,
    output logic             buffer_read_signal,
    output logic      [15:0] addend_value,
    output logic      [15:0] augend_value,
    output logic      [15:0] sum_value,
    output logic             adder_clear,
    output logic      [4:0]  edit_state
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        mbe_pkg::mbe_edit_t edit;
        logic [15:0]        buffer;
        logic [15:0]        addend;
        logic [15:0]        augend;
        logic [15:0]        sum;
        logic [15:0]        rd_data;
        logic               carry_in;
        logic [31:0]        prdata;
    } mbe_state_t;

    mbe_state_t st_r;
    mbe_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // decoded strobes

    logic        edit_set;
    logic        edit_clr;
    logic        buffer_edit_inhibit;
    logic        wg_norm;
    logic        buffer_low_write;
    logic        buffer_top_write;
    logic        buffer_rotate_left_write;
    logic        buffer_rotate_right_write;
    logic        buffer_shift_write;
    logic        buffer_extract_write;
    logic        muldiv_buffer_load_write;
    logic        buffer_clear;
    logic        buffer_clear_on_strobe;

    logic        augend_low_write;
    logic        augend_high_write;
    logic        augend_shift_write;
    logic        augend_shift_low_write;
    logic        shift_low_inhibit;
    logic        accum_to_addend_write;

    logic        apb_setup;
    logic        apb_write;
    logic        addr_hit;
    logic        sw_clr_edit;
    logic        sw_force_clr;

    logic [15:0] adder_sum;
    logic        adder_carry;
    mbe_pkg::mbe_edit_t edit_req;

    ////////////////////////////////////////////////////////////////////////
    // adder

    mbe_adder u_adder (
        .addend              (st_r.addend),
        .augend              (st_r.augend),
        .carry_in            (st_r.carry_in),
        .no_wraparound_carry (no_wraparound_carry),
        .sum                 (adder_sum),
        .carry_out           (adder_carry)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    always_comb begin
        apb_setup = psel & ~penable;
        apb_write = psel & penable & pwrite;
        unique case (paddr)
            mbe_pkg::OFS_CTRL,
            mbe_pkg::OFS_STATUS,
            mbe_pkg::OFS_BUFFER,
            mbe_pkg::OFS_ADDEND,
            mbe_pkg::OFS_AUGEND,
            mbe_pkg::OFS_SUM:    addr_hit = 1'b1;
            default:             addr_hit = 1'b0;
        endcase
        sw_clr_edit  = apb_write & (paddr == mbe_pkg::OFS_CTRL)
                     & pwdata[mbe_pkg::CTRL_CLR_EDIT];
        sw_force_clr = apb_write & (paddr == mbe_pkg::OFS_CTRL)
                     & pwdata[mbe_pkg::CTRL_FORCE_CLR];
    end

    // zero-wait slave: no access ever needs a wait state
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~addr_hit;
    assign prdata  = st_r.prdata;

    ////////////////////////////////////////////////////////////////////////
    // editing control

    always_comb begin
        unique case (mem_addr)
            mbe_pkg::ADDR_ROT_R:   edit_req = mbe_pkg::MBE_ROT_R;
            mbe_pkg::ADDR_SHIFT_R: edit_req = mbe_pkg::MBE_SHIFT_R;
            mbe_pkg::ADDR_ROT_L:   edit_req = mbe_pkg::MBE_ROT_L;
            mbe_pkg::ADDR_EXTRACT: edit_req = mbe_pkg::MBE_EXTRACT;
            default:               edit_req = mbe_pkg::MBE_IDLE;
        endcase
        edit_set = timing_pulse_2 & (edit_req != mbe_pkg::MBE_IDLE);
        edit_clr = memory_cycle_end | sw_clr_edit;
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer write service

    always_comb begin
        wg_norm = buffer_write_pulse_local & write_timing_pulse;
        // position 15 plays no part in shifts or cycles, so the whole
        // low write is held off while any editing flag stands
        buffer_edit_inhibit = (st_r.edit != mbe_pkg::MBE_IDLE);
        buffer_low_write    = wg_norm & ~buffer_edit_inhibit;
        buffer_top_write    = wg_norm & (~buffer_edit_inhibit
                            | st_r.edit == mbe_pkg::MBE_SHIFT_R);
        buffer_shift_write  = wg_norm
                            & (st_r.edit == mbe_pkg::MBE_SHIFT_R);
        buffer_rotate_left_write  = wg_norm
                            & (st_r.edit == mbe_pkg::MBE_ROT_L);
        buffer_rotate_right_write = wg_norm
                            & (st_r.edit == mbe_pkg::MBE_ROT_R);
        buffer_extract_write = wg_norm
                            & (st_r.edit == mbe_pkg::MBE_EXTRACT);
        muldiv_buffer_load_write = muldiv_buffer_load_pulse
                                 & transfer_timing_pulse
                                 & (multiply_active | divide_active);
        buffer_clear = (buffer_write_pulse_local | muldiv_buffer_load_pulse)
                     & clear_timing_pulse;
        buffer_clear_on_strobe = erasable_sense_strobe
                               | fixed_sense_strobe;
        buffer_read_signal = buffer_read_pulse & read_timing_pulse;
    end

    ////////////////////////////////////////////////////////////////////////
    // adder input service

    always_comb begin
        augend_low_write  = (augend_write_pulse | augend_low_only_pulse)
                          & write_timing_pulse;
        augend_high_write = augend_write_pulse & write_timing_pulse;
        augend_shift_write = augend_shift_pulse & write_timing_pulse
                           & (multiply_active | divide_active
                           | counter_shift_in_zero
                           | counter_shift_in_one);
        shift_low_inhibit = (multiply_active & low_reg[14])
                          | no_wraparound_carry
                          | counter_shift_in_zero;
        augend_shift_low_write = augend_shift_write & ~shift_low_inhibit;
        adder_clear = (augend_write_pulse | augend_low_only_pulse
                    | augend_shift_pulse) & clear_timing_pulse;
        accum_to_addend_write = accum_to_addend_pulse & write_timing_pulse
                              & (extracode_active | add_active);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;

        // a set in the same cycle as a clear wins, so no edit is lost
        if (edit_set) begin
            st_nxt.edit = edit_req;
        end else if (edit_clr) begin
            st_nxt.edit = mbe_pkg::MBE_IDLE;
        end

        // clears act first; writes in the same cycle land on top
        if (buffer_clear | buffer_clear_on_strobe | sw_force_clr) begin
            st_nxt.buffer = mbe_pkg::WORD_RST;
        end

        if (buffer_low_write) begin
            st_nxt.buffer[14:0] = write_lines[14:0];
        end
        if (buffer_top_write) begin
            st_nxt.buffer[15] = write_lines[15];
        end
        if (buffer_shift_write) begin
            st_nxt.buffer[13]   = write_lines[15];
            st_nxt.buffer[12:0] = write_lines[13:1];
        end
        if (buffer_rotate_left_write) begin
            st_nxt.buffer[15]   = write_lines[13];
            st_nxt.buffer[13:1] = write_lines[12:0];
            st_nxt.buffer[0]    = write_lines[15];
        end
        if (buffer_rotate_right_write) begin
            st_nxt.buffer[15]   = write_lines[0];
            st_nxt.buffer[13]   = write_lines[15];
            st_nxt.buffer[12:0] = write_lines[13:1];
        end
        if (buffer_extract_write) begin
            st_nxt.buffer[6:0] = write_lines[13:7];
        end
        // low register bit 15 is dropped; position 16 takes the sign
        if (muldiv_buffer_load_write) begin
            st_nxt.buffer[15]   = accumulator[15];
            st_nxt.buffer[14:1] = low_reg[13:0];
            st_nxt.buffer[0]    = multiply_bit_one_pulse;
        end

        // read data lasts one cycle, zero outside a timed read
        if (buffer_read_signal) begin
            st_nxt.rd_data = st_r.buffer;
        end else begin
            st_nxt.rd_data = mbe_pkg::WORD_RST;
        end

        // x and y are cleared together, then written
        if (adder_clear | sw_force_clr) begin
            st_nxt.addend   = mbe_pkg::WORD_RST;
            st_nxt.augend   = mbe_pkg::WORD_RST;
            st_nxt.carry_in = 1'b0;
        end
        if (carry_in_pulse) begin
            st_nxt.carry_in = 1'b1;
        end
        if (augend_low_write) begin
            st_nxt.augend[11:0] = write_lines[11:0];
        end
        if (augend_high_write) begin
            st_nxt.augend[15:12] = write_lines[15:12];
        end
        if (augend_shift_write) begin
            st_nxt.augend[15]   = write_lines[15];
            st_nxt.augend[14:1] = write_lines[13:0];
        end
        if (augend_shift_low_write) begin
            st_nxt.augend[0] = write_lines[15];
        end
        // x never sees the write lines; its one path is the accumulator
        if (accum_to_addend_write) begin
            st_nxt.addend = accumulator;
        end

        st_nxt.sum = adder_sum;

        // read data is captured in the setup cycle for a zero-wait answer
        if (apb_setup & ~pwrite) begin
            unique case (paddr)
                mbe_pkg::OFS_STATUS:
                    st_nxt.prdata = {26'h0, adder_carry, st_r.edit};
                mbe_pkg::OFS_BUFFER:
                    st_nxt.prdata = {16'h0000, st_r.buffer};
                mbe_pkg::OFS_ADDEND:
                    st_nxt.prdata = {16'h0000, st_r.addend};
                mbe_pkg::OFS_AUGEND:
                    st_nxt.prdata = {16'h0000, st_r.augend};
                mbe_pkg::OFS_SUM:
                    st_nxt.prdata = {16'h0000, st_r.sum};
                default:
                    st_nxt.prdata = mbe_pkg::RDATA_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r.edit     <= mbe_pkg::MBE_IDLE;
            st_r.buffer   <= mbe_pkg::WORD_RST;
            st_r.addend   <= mbe_pkg::WORD_RST;
            st_r.augend   <= mbe_pkg::WORD_RST;
            st_r.sum      <= mbe_pkg::WORD_RST;
            st_r.rd_data  <= mbe_pkg::WORD_RST;
            st_r.carry_in <= 1'b0;
            st_r.prdata   <= mbe_pkg::RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign buffer_value     = st_r.buffer;
    assign buffer_read_data = st_r.rd_data;
    assign addend_value     = st_r.addend;
    assign augend_value     = st_r.augend;
    assign sum_value        = st_r.sum;
    assign edit_state       = st_r.edit;

endmodule

// ===== dv/mbe_timer_model.sv
`timescale 1ns/1ps
module mbe_timer_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      timing_pulse_2,
    output logic      clear_timing_pulse,
    output logic      write_timing_pulse,
    output logic      transfer_timing_pulse,
    output logic      read_timing_pulse,
    output logic      memory_cycle_end
);
    logic [2:0] phase_r;
    logic [2:0] phase_nxt;

    // slow mode pads each memory cycle with three idle steps
    always_comb begin
        phase_nxt = phase_r + 3'h1;
        if (!slow && phase_r == 3'h4) begin
            phase_nxt = 3'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= 3'h0;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    assign timing_pulse_2        = phase_r == 3'h0;
    assign clear_timing_pulse    = phase_r == 3'h1;
    assign write_timing_pulse    = phase_r == 3'h2;
    assign transfer_timing_pulse = phase_r == 3'h2;
    assign read_timing_pulse     = phase_r == 3'h3;
    assign memory_cycle_end      = phase_r == 3'h4;
endmodule

// ===== dv/mbe_core_chk.sv
`timescale 1ns/1ps
module mbe_core_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        timing_pulse_2,
    input wire logic        memory_cycle_end,
    input wire logic        read_timing_pulse,
    input wire logic        clear_timing_pulse,
    input wire logic [11:0] mem_addr,
    input wire logic        buffer_read_pulse,
    input wire logic        buffer_write_pulse_local,
    input wire logic        muldiv_buffer_load_pulse,
    input wire logic        erasable_sense_strobe,
    input wire logic        fixed_sense_strobe,
    input wire logic        augend_write_pulse,
    input wire logic        augend_low_only_pulse,
    input wire logic        augend_shift_pulse,
    input wire logic [15:0] buffer_value,
    input wire logic [15:0] buffer_read_data,
    input wire logic        buffer_read_signal,
    input wire logic        adder_clear,
    input wire logic [4:0]  edit_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    property p_rd_sig;
        buffer_read_signal == (buffer_read_pulse && read_timing_pulse);
    endproperty
    a_rd_sig: assert property (p_rd_sig) else $error("read strobe wrong");
    property p_rd_data;
        buffer_read_signal |=> buffer_read_data == $past(buffer_value);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data wrong");
    property p_sr_set;
        timing_pulse_2 && mem_addr == mbe_pkg::ADDR_SHIFT_R
            |=> edit_state == mbe_pkg::MBE_SHIFT_R;
    endproperty
    a_sr_set: assert property (p_sr_set) else $error("no shift flag");
    property p_rl_set;
        timing_pulse_2 && mem_addr == mbe_pkg::ADDR_ROT_L
            |=> edit_state == mbe_pkg::MBE_ROT_L;
    endproperty
    a_rl_set: assert property (p_rl_set) else $error("no rotate flag");
    property p_ex_set;
        timing_pulse_2 && mem_addr == mbe_pkg::ADDR_EXTRACT
            |=> edit_state == mbe_pkg::MBE_EXTRACT;
    endproperty
    a_ex_set: assert property (p_ex_set) else $error("no extract flag");
    property p_ed_clr;
        memory_cycle_end && !timing_pulse_2 |=> edit_state == mbe_pkg::MBE_IDLE;
    endproperty
    a_ed_clr: assert property (p_ed_clr) else $error("flag not cleared");
    property p_strobe;
        (erasable_sense_strobe || fixed_sense_strobe) && !buffer_write_pulse_local
            && !muldiv_buffer_load_pulse |=> buffer_value == 16'h0000;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe kept buffer");
    property p_uclr;
        adder_clear == ((augend_write_pulse || augend_low_only_pulse
            || augend_shift_pulse) && clear_timing_pulse);
    endproperty
    a_uclr: assert property (p_uclr) else $error("adder clear wrong");
    c_extract: cover property (edit_state == mbe_pkg::MBE_EXTRACT);
    c_strobe: cover property (fixed_sense_strobe);
    c_read: cover property (buffer_read_signal);
endmodule

// ===== dv/mbe_core_tb_top.sv
`timescale 1ns/1ps
module mbe_core_tb_top;
    logic        clk, rst, slow, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        timing_pulse_2, write_timing_pulse, transfer_timing_pulse;
    logic        clear_timing_pulse, read_timing_pulse, memory_cycle_end;
    logic [11:0] mem_addr;
    logic        buffer_write_pulse_local, muldiv_buffer_load_pulse;
    logic        multiply_bit_one_pulse, buffer_read_pulse, multiply_active;
    logic        divide_active, extracode_active, add_active, carry_in_pulse;
    logic        accum_to_addend_pulse, augend_write_pulse, augend_shift_pulse;
    logic        augend_low_only_pulse, no_wraparound_carry;
    logic        counter_shift_in_zero, counter_shift_in_one;
    logic        erasable_sense_strobe, fixed_sense_strobe;
    logic [15:0] write_lines, accumulator, low_reg, sum_value;
    logic [15:0] buffer_value, buffer_read_data, addend_value, augend_value;
    logic        buffer_read_signal, adder_clear;
    logic [4:0]  edit_state;
    int          miscompares, checks_done;

    mbe_core mbe_core_inst (.*);
    mbe_timer_model mbe_timer_model_inst (.clk, .rst, .slow, .timing_pulse_2,
        .clear_timing_pulse, .write_timing_pulse, .transfer_timing_pulse,
        .read_timing_pulse, .memory_cycle_end);

    always #5 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic quiet();
        {buffer_write_pulse_local, muldiv_buffer_load_pulse,
         multiply_bit_one_pulse, buffer_read_pulse, multiply_active,
         divide_active, extracode_active, add_active, accum_to_addend_pulse,
         augend_write_pulse, augend_low_only_pulse, augend_shift_pulse,
         carry_in_pulse, no_wraparound_carry, counter_shift_in_zero,
         counter_shift_in_one, erasable_sense_strobe,
         fixed_sense_strobe} <= 18'h00000;
    endtask

    // controls are held for a whole memory cycle, framed by its end pulse
    task automatic begin_cycle(input logic [11:0] a, input logic [15:0] w);
        do @(posedge clk); while (memory_cycle_end !== 1'b1);
        mem_addr <= a;
        write_lines <= w;
    endtask

    task automatic finish_cycle();
        do @(posedge clk); while (memory_cycle_end !== 1'b1);
        quiet();
        #1;
    endtask

    function automatic logic [15:0] exp_buf(input logic [11:0] a,
                                            input logic [15:0] w);
        case (a)
            mbe_pkg::ADDR_ROT_R:   return {w[0], 1'b0, w[15], w[13:1]};
            mbe_pkg::ADDR_SHIFT_R: return {w[15], 1'b0, w[15], w[13:1]};
            mbe_pkg::ADDR_ROT_L:   return {w[13], 1'b0, w[12:0], w[15]};
            mbe_pkg::ADDR_EXTRACT: return {9'h000, w[13:7]};
            default:               return w;
        endcase
    endfunction
    ////////////////////////////////////////
    task automatic sc_edit();
        logic [11:0] a [6] = '{12'h000, 12'h010, 12'h011, 12'h012, 12'h013,
                               12'h000};
        for (int i = 0; i < 6; i++) begin
            begin_cycle(a[i], 16'hda35);
            buffer_write_pulse_local <= 1'b1;
            buffer_read_pulse <= 1'b1;
            finish_cycle();
            chk("buffer", exp_buf(a[i], 16'hda35), buffer_value);
            chk("edit state", mbe_pkg::MBE_IDLE, edit_state);
        end
    endtask

    task automatic sc_apb();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, mbe_pkg::OFS_BUFFER, 32'h0, rd, err);
        chk("buffer reg", 32'h0000da35, rd);
        apb(1'b0, 8'h18, 32'h0, rd, err);
        chk("unmapped err", 32'h1, err);
        apb(1'b1, mbe_pkg::OFS_SUM, 32'hffff, rd, err);
        chk("ro write err", 32'h0, err);
        apb(1'b1, mbe_pkg::OFS_CTRL, 32'h3, rd, err);
        apb(1'b0, mbe_pkg::OFS_BUFFER, 32'h0, rd, err);
        chk("force clear", 32'h0, rd);
        apb(1'b0, mbe_pkg::OFS_STATUS, 32'h0, rd, err);
        chk("status", 32'h1, rd);
    endtask

    task automatic sc_muldiv();
        logic [15:0] e [3] = '{16'hd555, 16'haaaa, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            begin_cycle(12'h000, 16'h0000);
            muldiv_buffer_load_pulse <= 1'b1;
            multiply_active <= (i == 0);
            divide_active <= (i == 1);
            multiply_bit_one_pulse <= (i == 0);
            accumulator <= 16'h8000;
            low_reg <= (i == 0) ? 16'h2aaa : 16'h1555;
            finish_cycle();
            chk("muldiv load", e[i], buffer_value);
        end
    endtask

    task automatic sc_strobe();
        for (int i = 0; i < 2; i++) begin
            begin_cycle(12'h000, 16'h1234);
            buffer_write_pulse_local <= 1'b1;
            finish_cycle();
            begin_cycle(12'h000, 16'h1234);
            erasable_sense_strobe <= (i == 0);
            fixed_sense_strobe <= (i == 1);
            finish_cycle();
            chk("strobe clear", 16'h0000, buffer_value);
        end
    endtask

    task automatic sc_adder();
        begin_cycle(12'h000, 16'h8001);
        add_active <= 1'b1;
        accum_to_addend_pulse <= 1'b1;
        augend_write_pulse <= 1'b1;
        accumulator <= 16'h8000;
        finish_cycle();
        chk("addend", 16'h8000, addend_value);
        chk("augend", 16'h8001, augend_value);
        chk("sum", 16'h0002, sum_value);
        begin_cycle(12'h000, 16'hffff);
        accum_to_addend_pulse <= 1'b1;
        carry_in_pulse <= 1'b1;
        accumulator <= 16'h1111;
        finish_cycle();
        chk("addend kept", 16'h8000, addend_value);
        chk("sum carry", 16'h0003, sum_value);
        begin_cycle(12'h000, 16'hffff);
        augend_low_only_pulse <= 1'b1;
        finish_cycle();
        chk("augend low", 16'h0fff, augend_value);
        chk("addend clr", 16'h0000, addend_value);
    endtask

    task automatic sc_shift();
        for (int i = 0; i < 5; i++) begin
            begin_cycle(12'h000, 16'h8001);
            augend_shift_pulse <= 1'b1;
            multiply_active <= (i < 2);
            low_reg <= (i == 1) ? 16'h4000 : 16'h0000;
            divide_active <= (i == 2);
            no_wraparound_carry <= (i == 2);
            counter_shift_in_zero <= (i == 3);
            counter_shift_in_one <= (i == 4);
            finish_cycle();
            chk("augend shift", {15'h4001, i == 0 || i == 4}, augend_value);
        end
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        slow = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = 43'h0;
        {mem_addr, write_lines, accumulator, low_reg} = 60'h0;
        miscompares = 0;
        checks_done = 0;
        quiet();
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        sc_edit();
        sc_apb();
        sc_muldiv();
        @(posedge clk) slow <= 1'b1;
        sc_strobe();
        sc_adder();
        sc_shift();
        close_out();
    end

    initial begin
        #40000;
        miscompares++;
        close_out();
    end
endmodule

bind mbe_core mbe_core_chk mbe_core_chk_inst (.*);
